/* verification/pia_far_model.sv */
`timescale 1ns/1ps
// ****************************************
// Processor and device multiplexer model
// ****************************************
module pia_far_model
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // From bench
  input wire logic stall_in,
  input wire logic [3:0] flag_in,
  // From arbiter
  input wire logic io_sync_pulse_in,
  input wire logic break_request_in,
  input wire logic [3:0] level_grant_in,
  // To arbiter
  output logic [3:0] level_request_out,
  output logic break_ack_out,
  output logic execute_state_out,
  output logic word33_out,
  // To bench
  output logic [3:0] addr_drive_out
);
  logic [3:0] req_q;
  logic [3:0] drive_q;
  logic [2:0] ph_q;
  // One unit per level, so its chain input is always open
  assign level_request_out = req_q;
  assign break_ack_out = (ph_q == 3'h2) || (ph_q == 3'h3);
  assign execute_state_out = (ph_q == 3'h2);
  assign word33_out = break_ack_out;
  assign addr_drive_out = drive_q;
  // grant sets drive, sync after grant drops clears it
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      drive_q <= 4'h0;
    else
      drive_q <= level_grant_in | (drive_q & ~{4{io_sync_pulse_in}});
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      req_q <= 4'h0;
    else
      req_q <= flag_in & (req_q | {4{io_sync_pulse_in}});
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      ph_q <= 3'h0;
    else if (ph_q != 3'h0)
      ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
    else if (break_request_in && !stall_in)
      ph_q <= 3'h1;
  end
endmodule

/* verification/priority_interrupt_arbiter_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t: got %0h want %0h", $time, (a), (b)); end end
module priority_interrupt_arbiter_bench;
  logic sys_clk_in = 0, rst_in = 1, cpp = 0, dma = 0, io_transfer_instr = 0, seg = 0, fio = 0, debreak_instr = 0, debreak_restore_instr = 0;
  logic wr = 0, rd = 0, stall = 0, exe, w33, ack, sync, bkrq, lblk, cpc, cpc_seen = 0;
  logic [5:0] dsel = 6'h00;
  logic [17:0] bus = 18'h00000;
  logic [3:0] flag = 4'h0, lreq, gnt, drv, addr = 4'h0;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [2:0] blev;
  logic [1:0] rlev;
  int n_fail = 0, tests_run = 0;
  localparam logic [17:0] EN = 18'h20000;
  localparam logic [31:0] ACT = 32'h000FF;
  // ****************************************
  // Clocking and instances
  // ****************************************
  always #50 sys_clk_in = !sys_clk_in;
  // Processor strobe every other cycle
  always @(posedge sys_clk_in) cpp <= !cpp && !rst_in;
  always @(posedge sys_clk_in) if (cpc === 1'b1) cpc_seen <= 1'b1;
  pia_arbiter DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clock_positive_pulse_in(cpp), .dma_sync_in(dma),
    .io_transfer_instr_in(io_transfer_instr), .break_segment_in(seg), .fourth_io_pulse_in(fio), .device_select_in(dsel),
    .io_bus_in(bus), .execute_state_in(exe), .processor_word33_in(w33), .break_ack_in(ack),
    .debreak_instr_in(debreak_instr), .debreak_restore_instr_in(debreak_restore_instr), .level_request_in(lreq), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .io_sync_pulse_out(sync),
    .break_request_out(bkrq), .level_grant_out(gnt), .legacy_interrupt_block_out(lblk),
    .clear_page_counter_out(cpc), .break_level_out(blev), .reader_level_out(rlev));
  pia_far_model far (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .stall_in(stall), .flag_in(flag),
    .io_sync_pulse_in(sync), .break_request_in(bkrq), .level_grant_in(gnt), .level_request_out(lreq),
    .break_ack_out(ack), .execute_state_out(exe), .word33_out(w33), .addr_drive_out(drv));
  // ****************************************
  // Bus and wait helpers
  // ****************************************
  task automatic setpri(input logic [17:0] v);
    @(posedge sys_clk_in) addr <= pia_pkg::ADDR_SETPRI;
    wdata <= {14'h0000, v};
    wr <= 1;
    @(posedge sys_clk_in) wr <= 0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk_in) addr <= a;
    rd <= 1;
    @(posedge sys_clk_in) rd <= 0;
    #1 `CHK(rdata & m, e)
  endtask
  task automatic debreak(input logic r);
    @(posedge sys_clk_in) debreak_instr <= !r;
    debreak_restore_instr <= r;
    @(posedge sys_clk_in) debreak_instr <= 0;
    debreak_restore_instr <= 0;
    #1;
  endtask
  // Waits for the break, checks level and grant, then waits for entry
  task automatic brk(input logic [2:0] lv, input logic [3:0] g);
    int i;
    i = 0;
    while (bkrq !== 1'b1 && i < 200) begin @(posedge sys_clk_in); #1; i++; end
    `CHK(blev, lv)
    `CHK(gnt, g)
    while (bkrq === 1'b1 && i < 220 && !stall) begin @(posedge sys_clk_in); #1; i++; end
    `CHK(gnt, stall ? g : 4'h0)
    repeat (4) @(posedge sys_clk_in);
    #1 `CHK(drv, stall ? g : 4'h0)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    `CHK(({bkrq, gnt, lblk, rlev}), 8'h02)
    rd_chk(pia_pkg::ADDR_STATUS, 32'h3FFFF, 32'h0);
    rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_iosync;
    int k, n;
    for (k = 0; k < 3; k++) begin
      @(posedge sys_clk_in) dma <= (k == 0);
      io_transfer_instr <= (k == 1);
      n = 0;
      repeat (12) begin @(posedge sys_clk_in); #1; n += sync; end
      `CHK(n == 0, k != 2)
    end
  endtask
  task automatic t_soft;
    setpri(EN);
    rd_chk(pia_pkg::ADDR_STATUS, 32'h1 << pia_pkg::ST_ENABLE, 32'h1 << pia_pkg::ST_ENABLE);
    `CHK(lblk, 1'b0)
    setpri(EN | (18'h1 << (pia_pkg::BIT_SW4 - 3)));
    brk(3'h7, 4'h0);
    rd_chk(pia_pkg::ADDR_STATUS, ACT, 32'h1);
    `CHK(lblk, 1'b1)
    `CHK(cpc_seen, 1'b1)
  endtask
  task automatic t_hw;
    flag <= 4'h4;
    brk(3'h2, 4'h4);
    flag <= 4'h0;
    debreak(0);
    rd_chk(pia_pkg::ADDR_STATUS, ACT, 32'h1);
    debreak(1);
    rd_chk(pia_pkg::ADDR_STATUS, ACT, 32'h0);
    `CHK(lblk, 1'b0)
  endtask
  task automatic t_block;
    setpri(EN | (18'h1 << (pia_pkg::BIT_RAISE0 - 3)));
    rd_chk(pia_pkg::ADDR_STATUS, ACT, 32'h10);
    setpri(EN | (18'h1 << (pia_pkg::BIT_SW4 - 1)));
    repeat (30) @(posedge sys_clk_in);
    #1 `CHK(bkrq, 1'b0)
    debreak(0);
    brk(3'h5, 4'h0);
    debreak(0);
    flag <= 4'hA;
    brk(3'h1, 4'h2);
    flag <= 4'h8;
    debreak(0);
    brk(3'h3, 4'h8);
    flag <= 4'h0;
    debreak(0);
  endtask
  task automatic t_strobe;
    stall <= 1;
    flag <= 4'h1;
    brk(3'h0, 4'h1);
    @(posedge sys_clk_in) dsel <= pia_pkg::DEV_SELECT;
    fio <= 1;
    flag <= 4'h0;
    @(posedge sys_clk_in) fio <= 0;
    #1 `CHK(({bkrq, gnt}), 5'h00)
    rd_chk(pia_pkg::ADDR_STATUS, 32'h1 << pia_pkg::ST_ENABLE, 32'h0);
    stall <= 0;
    setpri(EN | (18'h1 << pia_pkg::BIT_RDR0));
    `CHK(rlev, 2'h0)
    setpri(EN | (18'h1 << pia_pkg::BIT_RDR1));
    `CHK(rlev, 2'h1)
    setpri(EN);
    `CHK(rlev, 2'h2)
  endtask
  // ****************************************
  // Sequence, watchdog and verdict
  // ****************************************
  task automatic conclude;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 0;
    @(posedge sys_clk_in);
    #1;
    t_reset();
    t_iosync();
    t_soft();
    t_hw();
    t_block();
    t_strobe();
    conclude();
  end
  // Whole run is well under 2000 cycles
  initial
  begin
    #(5000 * 100);
    n_fail++;
    conclude();
  end
endmodule

/* verilog/pia_arbiter.sv */
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module pia_arbiter
#(
  parameter logic [5:0] DEV_SEL = pia_pkg::DEV_SELECT
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Processor I/O control
  input wire logic clock_positive_pulse_in,
  input wire logic dma_sync_in,
  input wire logic io_transfer_instr_in,
  input wire logic break_segment_in,
  input wire logic fourth_io_pulse_in,
  input wire logic [5:0] device_select_in,
  input wire logic [pia_pkg::BUS_W-1:0] io_bus_in,
  input wire logic execute_state_in,
  input wire logic processor_word33_in,
  input wire logic break_ack_in,
  input wire logic debreak_instr_in,
  input wire logic debreak_restore_instr_in,
  // Device multiplexers
  input wire logic [pia_pkg::HW_LEVELS-1:0] level_request_in,
  // Register port
  input wire logic [pia_pkg::ADDR_W-1:0] addr_in,
  input wire logic [pia_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [pia_pkg::DATA_W-1:0] rdata_out,
  // To processor and devices
  output logic io_sync_pulse_out,
  output logic break_request_out,
  output logic [pia_pkg::HW_LEVELS-1:0] level_grant_out,
  output logic legacy_interrupt_block_out,
  output logic clear_page_counter_out,
  output logic [2:0] break_level_out,
  output logic [1:0] reader_level_out
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  initial
  begin
    if (pia_pkg::LEVELS != 2 * pia_pkg::HW_LEVELS)
      $error("pia_arbiter: level count must be twice hardware levels");
    if (pia_pkg::BUS_W != 18)
      $error("pia_arbiter: bus must be 18 bits");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Mask of bits strictly above the lowest-index set bit cleared
  function automatic logic [7:0] lowest_one(input logic [7:0] v);
    lowest_one = v & (~v + 8'h01);
  endfunction

  // Bit n true when no bit at index <= n is set (carry chain)
  function automatic logic [7:0] none_at_or_above(input logic [7:0] v);
    logic [7:0] r;
    logic seen;
    r = 8'h00;
    seen = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      seen = seen | v[i];
      r[i] = ~seen;
    end
    none_at_or_above = r;
  endfunction

  function automatic logic [2:0] encode8(input logic [7:0] onehot);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++)
      if (onehot[i])
        r = 3'(i);
    encode8 = r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic enable_q, enable_d;
  logic [7:0] active_q, active_d;
  logic [3:0] swreq_q, swreq_d;
  logic [1:0] rdr_ctl_q, rdr_ctl_d;
  logic pre_sync_q, pre_sync_d;
  logic sync_q, sync_d;
  logic bkrq_q, bkrq_d;
  logic [3:0] grant_q, grant_d;
  logic [2:0] tgt_q, tgt_d;
  logic exec_q;
  logic io_sync_q;
  logic block_q;
  logic page_clr_q;
  logic [1:0] rdr_level_q;
  logic [pia_pkg::DATA_W-1:0] rdata_q;
  logic [17:0] status_w;
  logic [pia_pkg::DATA_W-1:0] rd_mux;

  // ****************************************
  // Decode
  // ****************************************
  wire logic reg_setpri = wr_in && (addr_in == pia_pkg::ADDR_SETPRI);
  wire logic iot_strobe = fourth_io_pulse_in && (device_select_in == DEV_SEL);
  wire logic set_priority_instr = iot_strobe || reg_setpri;
  // The pins are taken over a register write when both land together
  wire logic [17:0] bus = iot_strobe ? io_bus_in : wdata_in[17:0];
  wire logic debreak = debreak_instr_in || debreak_restore_instr_in;
  wire logic entry_done = processor_word33_in && exec_q && !execute_state_in;
  wire logic hold_off = break_segment_in || io_transfer_instr_in;
  // Requests by level, level 0 in bit 0
  // level numbering
  wire logic [7:0] req_vec = enable_q ? {swreq_q, level_request_in} : 8'h00;
  wire logic [7:0] level_allow = none_at_or_above(active_q);
  wire logic [7:0] req_win = lowest_one(req_vec);
  wire logic [7:0] sync_gate = req_win & level_allow;
  wire logic any_gate = |sync_gate;
  wire logic [7:0] raise_sel;
  // Software request field: bit 06+k requests level 4+k
  wire logic [3:0] sw_sel;
  for (genvar n = 0; n < 8; n++)
  begin : g_raise
    assign raise_sel[n] = bus[pia_pkg::BIT_RAISE0 - n];
  end
  for (genvar k = 0; k < 4; k++)
  begin : g_sw
    assign sw_sel[k] = bus[pia_pkg::BIT_SW4 - k];
  end
  wire logic [7:0] raise_ok = (raise_sel & level_allow) & {8{bus[pia_pkg::BIT_ENABLE]}};
  wire logic [7:0] debreak_clr = debreak ? lowest_one(active_q) : 8'h00;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    enable_d = set_priority_instr ? bus[pia_pkg::BIT_ENABLE] : enable_q;
    rdr_ctl_d = rdr_ctl_q;
    if (set_priority_instr && bus[pia_pkg::BIT_ENABLE])
      rdr_ctl_d = {bus[pia_pkg::BIT_RDR0], bus[pia_pkg::BIT_RDR1]};
    // Entry and raise set levels; a set in the same cycle beats a debreak
    active_d = active_q & ~debreak_clr;
    if (entry_done)
      active_d[tgt_q] = 1'b1;
    if (set_priority_instr)
      active_d = active_d | raise_ok;
    swreq_d = swreq_q;
    if (entry_done && tgt_q[2])
      swreq_d[tgt_q[1:0]] = 1'b0;
    if (set_priority_instr && bus[pia_pkg::BIT_ENABLE])
      swreq_d = swreq_d | sw_sel;
    pre_sync_d = pre_sync_q;
    tgt_d = tgt_q;
    if (io_sync_q && any_gate && !pre_sync_q && !break_segment_in)
    begin
      pre_sync_d = 1'b1;
      tgt_d = encode8(sync_gate);
    end
    sync_d = sync_q;
    bkrq_d = bkrq_q;
    grant_d = grant_q;
    if (pre_sync_q && !sync_q && clock_positive_pulse_in && !hold_off)
    begin
      sync_d = 1'b1;
      bkrq_d = 1'b1;
      if (!tgt_q[2])
        grant_d[tgt_q[1:0]] = 1'b1;
    end
    if (entry_done)
    begin
      pre_sync_d = 1'b0;
      sync_d = 1'b0;
      bkrq_d = 1'b0;
      grant_d = 4'h0;
    end
    if (set_priority_instr)
    begin
      pre_sync_d = 1'b0;
      sync_d = 1'b0;
      bkrq_d = 1'b0;
      grant_d = 4'h0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // reset state
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      enable_q <= 1'b0;
      active_q <= pia_pkg::ACTIVE_RST;
      swreq_q <= pia_pkg::SWREQ_RST;
      rdr_ctl_q <= pia_pkg::RDR_CTL_RST;
      pre_sync_q <= 1'b0;
      sync_q <= 1'b0;
      bkrq_q <= 1'b0;
      grant_q <= 4'h0;
      tgt_q <= 3'h0;
    end
    else
    begin
      enable_q <= enable_d;
      active_q <= active_d;
      swreq_q <= swreq_d;
      rdr_ctl_q <= rdr_ctl_d;
      pre_sync_q <= pre_sync_d;
      sync_q <= sync_d;
      bkrq_q <= bkrq_d;
      grant_q <= grant_d;
      tgt_q <= tgt_d;
    end
  end

  // Output stage; every output but break_request_out, level_grant_out and break_level_out comes from here
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      exec_q <= 1'b0;
      io_sync_q <= 1'b0;
      block_q <= 1'b0;
      page_clr_q <= 1'b0;
      rdr_level_q <= pia_pkg::RDR_LEVEL_DEFAULT;
      rdata_q <= '0;
    end
    else
    begin
      exec_q <= execute_state_in;
      io_sync_q <= clock_positive_pulse_in && !dma_sync_in && !io_transfer_instr_in;
      block_q <= enable_d && (pre_sync_d || (|active_d));
      page_clr_q <= bkrq_q && break_ack_in;
      rdr_level_q <= (rdr_ctl_d == pia_pkg::RDR_CTL_LEVEL0) ? 2'h0 :
        (rdr_ctl_d == pia_pkg::RDR_CTL_LEVEL1) ? 2'h1 : pia_pkg::RDR_LEVEL_DEFAULT;
      rdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_comb
  begin
    status_w = 18'h00000;
    status_w[pia_pkg::ST_ENABLE] = enable_q;
    for (int n = 0; n < 8; n++)
    begin
      status_w[pia_pkg::ST_REQ0 - n] = req_vec[n];
      status_w[pia_pkg::ST_ACT0 - n] = active_q[n];
    end
    rd_mux = '0;
    if (rd_in && addr_in == pia_pkg::ADDR_STATUS)
      rd_mux = {14'h0000, status_w};
    else if (rd_in && addr_in == pia_pkg::ADDR_STATE)
      rd_mux = {23'h000000, rdr_level_q, tgt_q, pre_sync_q, sync_q, bkrq_q, grant_q[0]};
  end

  assign rdata_out = rdata_q;
  assign io_sync_pulse_out = io_sync_q;
  assign break_request_out = bkrq_q;
  assign level_grant_out = grant_q;
  assign legacy_interrupt_block_out = block_q;
  assign clear_page_counter_out = page_clr_q;
  assign break_level_out = tgt_q;
  assign reader_level_out = rdr_level_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_io_sync;
    io_sync_q |-> $past(clock_positive_pulse_in) && !$past(dma_sync_in) && !$past(io_transfer_instr_in);
  endproperty
  a_io_sync: assert property (p_io_sync) else $error("io sync without permission");
  property p_block;
    enable_q && (|active_q) |-> block_q;
  endproperty
  a_block: assert property (p_block) else $error("legacy not blocked");
  property p_defer;
    $rose(sync_q) |-> $past(clock_positive_pulse_in) && !$past(hold_off) && $past(pre_sync_q);
  endproperty
  a_defer: assert property (p_defer) else $error("break sync not deferred");
  property p_grant;
    $rose(bkrq_q) && !tgt_q[2] |-> grant_q[tgt_q[1:0]] && $onehot(grant_q);
  endproperty
  a_grant: assert property (p_grant) else $error("grant missing with break");
  property p_page;
    bkrq_q && break_ack_in |=> page_clr_q;
  endproperty
  a_page: assert property (p_page) else $error("page counter not cleared");
  property p_entry;
    entry_done && !set_priority_instr |=> !bkrq_q && !sync_q && (grant_q == 4'h0) && active_q[$past(tgt_q)];
  endproperty
  a_entry: assert property (p_entry) else $error("entry did not settle");
  property p_strobe_clear;
    set_priority_instr |=> !bkrq_q && !pre_sync_q && !sync_q && (grant_q == 4'h0);
  endproperty
  a_strobe_clear: assert property (p_strobe_clear) else $error("strobe did not clear");
  property p_enable;
    set_priority_instr |=> enable_q == $past(bus[pia_pkg::BIT_ENABLE]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not loaded");
  // Gated level must rank strictly above the highest active level
  property p_allow;
    (|sync_gate) |-> $onehot0(sync_gate) && (active_q == 8'h00 || encode8(sync_gate) < encode8(lowest_one(active_q)));
  endproperty
  a_allow: assert property (p_allow) else $error("blocked level gated");
  property p_debreak;
    debreak && !set_priority_instr && !entry_done && (|active_q) |=> !active_q[$past(encode8(lowest_one(active_q)))];
  endproperty
  a_debreak: assert property (p_debreak) else $error("debreak missed level");
  c_break: cover property ($rose(bkrq_q) ##[1:50] entry_done);
  c_raise: cover property (set_priority_instr && (|raise_ok));
  c_debreak: cover property (debreak && (|active_q));

endmodule

/* verilog/pia_pkg.sv */
package pia_pkg;
  // Register map on the plain register port (byte addresses)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_SETPRI = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // I/O bus word: accumulator bit k sits at index 17-k
  localparam int BUS_W = 18;
  localparam int BIT_ENABLE = 17;
  localparam int BIT_RDR0 = 16;
  localparam int BIT_RDR1 = 15;
  localparam int BIT_SW4 = 11;
  localparam int BIT_RAISE0 = 7;
  // Status word positions (same bit-k-at-17-k order)
  localparam int ST_ENABLE = 17;
  localparam int ST_REQ0 = 15;
  localparam int ST_ACT0 = 7;
  // Device select code of the set-priority instruction
  localparam logic [5:0] DEV_SELECT = 6'h2D;
  // Levels: 0 highest, 7 lowest; 0..3 hardware, 4..7 software
  localparam int LEVELS = 8;
  localparam int HW_LEVELS = 4;
  // Reader level codes
  localparam logic [1:0] RDR_LEVEL_DEFAULT = 2'h2;
  localparam logic [1:0] RDR_CTL_LEVEL0 = 2'h2;
  localparam logic [1:0] RDR_CTL_LEVEL1 = 2'h1;
  // Reset values
  localparam logic [7:0] ACTIVE_RST = 8'h00;
  localparam logic [3:0] SWREQ_RST = 4'h0;
  localparam logic [1:0] RDR_CTL_RST = 2'h0;
endpackage
